// >>> tb/host_model.sv
// host model that sends protection command frames
`timescale 1ns/1ps
module host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
    end
    // ----------
    // frame: opcode, address if ad, n data bytes low byte first
    // ----------
    task automatic frame(input logic [7:0] op, input bit ad, input logic [23:0] a, input int n,
        input logic [63:0] d, output logic [63:0] r);
        logic [7:0] b;
        r = '0;
        cs_n_o = 1'b0;
        #100;
        for (int k = -4; k < n; k++) begin
            if (k > -4 && k < 0 && !ad) continue;
            b = k == -4 ? op : k < 0 ? a[8 * (-k - 1) +: 8] : d[8 * k +: 8];
            for (int i = 7; i >= 0; i--) begin
                sdi_o = b[i];
                #62.5 sclk_o = 1'b1;
                if (k >= 0) r[8 * k + i] = sdo_i;
                #62.5 sclk_o = 1'b0;
            end
        end
        // released line shows no stale value
        sdi_o = ~sdi_o;
        #100 cs_n_o = 1'b1;
        #600;
    endtask
endmodule

// >>> tb/protect_assertions.sv
// port checks for the protection block
`timescale 1ns/1ps
module protect_assertions #(
    parameter int unsigned PROG_TIME_NS = 50000,
    parameter int unsigned ERASE_TIME_NS = 1000000
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic soft_rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdo_o,
    input wire logic [23:0] wp_addr_i,
    input wire logic wp_block_o,
    input wire logic busy_o
);
    localparam int PCYC = PROG_TIME_NS / protect_pkg::CLK_PERIOD_NS;
    localparam int ECYC = ERASE_TIME_NS / protect_pkg::CLK_PERIOD_NS;
    int blen_q, quiet_q, fall_q, csch_q;
    logic sclk_q, cs_q;
    // ----------
    // cycles since busy start, command end, sclk fall, cs change
    // ----------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            blen_q <= 0;
            quiet_q <= 0;
            fall_q <= 0;
            csch_q <= 0;
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
        end else begin
            blen_q <= busy_o ? blen_q + 1 : 0;
            quiet_q <= (cs_n_i && !cs_q) || soft_rst_i ? 0 : quiet_q + 1;
            fall_q <= sclk_q && !sclk_i ? 0 : fall_q + 1;
            csch_q <= cs_n_i != cs_q || soft_rst_i ? 0 : csch_q + 1;
            sclk_q <= sclk_i;
            cs_q <= cs_n_i;
        end
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    AST_BUSY_LEN: assert property ($fell(busy_o) |-> blen_q == PCYC || blen_q == ECYC)
        else $error("busy length wrong");
    AST_BUSY_BOUND: assert property (busy_o |-> blen_q < ECYC)
        else $error("busy too long");
    AST_BUSY_CAUSE: assert property ($rose(busy_o) |-> cs_n_i && quiet_q <= 8)
        else $error("busy without command");
    AST_SDO_IDLE: assert property (cs_n_i [*6] |-> !sdo_o)
        else $error("sdo not idle");
    AST_SDO_EDGE: assert property ($changed(sdo_o) |-> fall_q <= 5 || csch_q <= 5)
        else $error("sdo moved off edge");
    AST_BLOCK_CAUSE: assert property ($changed(wp_block_o) |->
        $past(wp_addr_i) != $past(wp_addr_i, 2) || quiet_q <= 12) else $error("block moved alone");
    AST_BLOCK_STEADY: assert property ((cs_n_i && $stable(wp_addr_i)) [*3] ##0 quiet_q > 12
        |=> $stable(wp_block_o)) else $error("block not steady");
    AST_REL_QUIET: assert property ($past(rst_i) |-> !busy_o && !wp_block_o && !sdo_o)
        else $error("not factory after reset");
    COV_BUSY: cover property ($rose(busy_o));
    COV_BLOCK: cover property ($rose(wp_block_o));
    COV_READ: cover property (!cs_n_i && sdo_o);
endmodule

bind sector_password_protection protect_assertions #(
    .PROG_TIME_NS(PROG_TIME_NS),
    .ERASE_TIME_NS(ERASE_TIME_NS)
) u_chk (
    .mclk_i(mclk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
    .sdo_o(sdo_o), .wp_addr_i(wp_addr_i), .wp_block_o(wp_block_o), .busy_o(busy_o)
);

// >>> tb/sector_password_protection_tb_top.sv
// self-checking bench for the protection block
`timescale 1ns/1ps
module sector_password_protection_tb_top;
    localparam int unsigned PROG_NS = 100;
    localparam int unsigned ERASE_NS = 300;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic soft_rst_i = 1'b0;
    logic [23:0] wp_addr_i = '0;
    logic sclk, cs_n, sdi, sdo, blk_o, busy;
    logic [63:0] rx, pw;
    logic [23:0] a, t;
    logic [3:0] u;
    logic nv_s [256];
    logic [1:0] vol_s [4096];
    int n_mismatch = 0;
    int num_checks = 0;
    int nbusy = 0;
    int b0;

    sector_password_protection #(.PROG_TIME_NS(PROG_NS), .ERASE_TIME_NS(ERASE_NS)) dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .sdi_i(sdi), .sdo_o(sdo), .wp_addr_i(wp_addr_i), .wp_block_o(blk_o), .busy_o(busy)
    );
    host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo));

    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        if (busy === 1'b1) nbusy <= nbusy + 1;
    end
    // ----------
    // helpers
    // ----------
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // end sectors keep one volatile slot per subsector
    function automatic int slot(input logic [23:0] ad);
        return ad[23:16] == 8'h00 || ad[23:16] == 8'hff ? int'(ad[23:12]) : int'({ad[23:16], 4'h0});
    endfunction
    function automatic logic eb(input logic [23:0] ad);
        return !nv_s[ad[23:16]] || vol_s[slot(ad)][0];
    endfunction
    task automatic blk(input logic [23:0] ad);
        @(posedge mclk_i) wp_addr_i <= ad;
        repeat (3) @(posedge mclk_i);
        #1 chk(64'(blk_o), 64'(eb(ad)));
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] ad, input int n, input logic [63:0] d);
        host.frame(op, op inside {protect_pkg::OP_RD_NV, protect_pkg::OP_WR_NV, protect_pkg::OP_RD_VOL,
            protect_pkg::OP_WR_VOL}, ad, n, d, rx);
    endtask
    task automatic rd(input logic [7:0] op, input logic [23:0] ad, input int n, input logic [63:0] e);
        cmd(op, ad, n, '0);
        chk(rx, e);
    endtask
    task automatic sreset(input bit hard);
        @(posedge mclk_i);
        rst_i <= hard;
        soft_rst_i <= !hard;
        @(posedge mclk_i);
        rst_i <= 1'b0;
        soft_rst_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        foreach (vol_s[i]) vol_s[i] = 2'b00;
        if (hard) foreach (nv_s[i]) nv_s[i] = 1'b1;
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ----------
    // scenarios
    // ----------
    initial begin
        void'($urandom(80));
        repeat (4) @(posedge mclk_i);
        sreset(1'b1);
        rd(protect_pkg::OP_RD_PROT, '0, 2, 64'hffff);
        rd(protect_pkg::OP_RD_FRZ, '0, 1, 64'h1);
        a = {8'($urandom_range(1, 127)), 16'($urandom)};
        t = {8'($urandom_range(128, 254)), 16'($urandom)};
        rd(protect_pkg::OP_RD_NV, a, 1, 64'h1);
        b0 = nbusy;
        cmd(protect_pkg::OP_WR_NV, a, 0, '0);
        nv_s[a[23:16]] = 1'b0;
        chk(64'(nbusy - b0), 64'(PROG_NS / protect_pkg::CLK_PERIOD_NS));
        blk(a);
        rd(protect_pkg::OP_RD_NV, a, 1, 64'h0);
        cmd(protect_pkg::OP_WR_FRZ, '0, 1, '0);
        rd(protect_pkg::OP_RD_FRZ, '0, 1, 64'h0);
        cmd(protect_pkg::OP_WR_NV, t, 0, '0);
        cmd(protect_pkg::OP_ER_NV, '0, 0, '0);
        blk(t);
        blk(a);
        pw = {$urandom, $urandom} & ~64'h1;
        cmd(protect_pkg::OP_UNLOCK, '0, 8, pw);
        rd(protect_pkg::OP_RD_FRZ, '0, 1, 64'h0);
        cmd(protect_pkg::OP_UNLOCK, '0, 8, protect_pkg::PW_RESET);
        rd(protect_pkg::OP_RD_FRZ, '0, 1, 64'h1);
        b0 = nbusy;
        cmd(protect_pkg::OP_ER_NV, '0, 0, '0);
        foreach (nv_s[i]) nv_s[i] = 1'b1;
        chk(64'(nbusy - b0), 64'(ERASE_NS / protect_pkg::CLK_PERIOD_NS));
        blk(a);
        cmd(protect_pkg::OP_WR_VOL, t, 1, 64'h1);
        vol_s[slot(t)] = 2'b01;
        blk({t[23:16], 16'($urandom)});
        u = 4'($urandom);
        cmd(protect_pkg::OP_WR_VOL, {8'hff, u, 12'h0}, 1, 64'h1);
        vol_s[slot({8'hff, u, 12'h0})] = 2'b01;
        blk({8'hff, u, 12'h0});
        blk({8'hff, u + 4'h1, 12'h0});
        cmd(protect_pkg::OP_WR_VOL, t, 1, 64'h3);
        cmd(protect_pkg::OP_WR_VOL, t, 1, 64'h0);
        vol_s[slot(t)] = 2'b11;
        rd(protect_pkg::OP_RD_VOL, t, 1, 64'h3);
        blk(t);
        cmd(protect_pkg::OP_WR_FRZ, '0, 1, '0);
        sreset(1'b0);
        blk(t);
        rd(protect_pkg::OP_RD_VOL, t, 1, 64'h0);
        rd(protect_pkg::OP_RD_FRZ, '0, 1, 64'h1);
        pw = {$urandom, $urandom};
        cmd(protect_pkg::OP_WR_PW, '0, 8, pw);
        rd(protect_pkg::OP_RD_PW, '0, 8, pw);
        cmd(protect_pkg::OP_WR_PROT, '0, 2, 64'hfffb);
        cmd(protect_pkg::OP_WR_PROT, '0, 2, 64'hfffd);
        rd(protect_pkg::OP_RD_PROT, '0, 2, 64'hfffb);
        cmd(protect_pkg::OP_WR_PW, '0, 8, ~pw);
        rd(protect_pkg::OP_RD_PW, '0, 8, '1);
        sreset(1'b0);
        rd(protect_pkg::OP_RD_FRZ, '0, 1, 64'h0);
        cmd(protect_pkg::OP_UNLOCK, '0, 8, ~pw);
        rd(protect_pkg::OP_RD_FRZ, '0, 1, 64'h0);
        cmd(protect_pkg::OP_UNLOCK, '0, 8, pw);
        rd(protect_pkg::OP_RD_FRZ, '0, 1, 64'h1);
        sreset(1'b1);
        cmd(protect_pkg::OP_WR_PROT, '0, 2, 64'hfffd);
        cmd(protect_pkg::OP_WR_PROT, '0, 2, 64'hfffb);
        rd(protect_pkg::OP_RD_PROT, '0, 2, 64'hfffd);
        cmd(protect_pkg::OP_WR_FRZ, '0, 1, '0);
        sreset(1'b0);
        rd(protect_pkg::OP_RD_FRZ, '0, 1, 64'h1);
        report_and_stop();
    end
    initial begin
        #800000;
        n_mismatch++;
        report_and_stop();
    end
endmodule

// >>> verilog/busy_timer.sv
// down counter that holds busy for the length of a nonvolatile update
`timescale 1ns/1ps
module busy_timer #(
    parameter int W = 32
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [W-1:0] len_i,
    output logic busy_o
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic busy;
    } tmr_t;

    tmr_t q;
    tmr_t d;

    always_comb begin
        d = q;
        if (start_i) begin
            d.cnt = len_i;
        end else if (q.cnt != '0) begin
            d.cnt = q.cnt - 1'b1;
        end
        d.busy = (d.cnt != '0);
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign busy_o = q.busy;

endmodule

// >>> verilog/link_sampler.sv
// serial link front end: synchronises the pins, finds clock edges, shifts bytes
`timescale 1ns/1ps
module link_sampler (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    input wire logic [7:0] tx_byte_i,
    output logic rx_valid_o,
    output logic [7:0] rx_byte_o,
    output logic frame_start_o,
    output logic frame_end_o,
    output logic sdo_o
);

    typedef struct packed {
        logic [2:0] cs;
        logic [2:0] ck;
        logic [1:0] di;
        logic [7:0] rx;
        logic [2:0] cnt;
        logic [7:0] tx;
        logic reload;
        logic rx_v;
        logic [7:0] rx_b;
        logic f_start;
        logic f_end;
    } link_t;

    link_t q;
    link_t d;
    logic rise;
    logic fall;
    logic active;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.rx_v = 1'b0;
        d.f_start = 1'b0;
        d.f_end = 1'b0;
        d.cs = {q.cs[1:0], cs_n_i};
        d.ck = {q.ck[1:0], sclk_i};
        d.di = {q.di[0], sdi_i};
        active = ~q.cs[1];
        rise = q.ck[1] & ~q.ck[2];
        fall = ~q.ck[1] & q.ck[2];
        if (q.cs[2] & ~q.cs[1]) begin
            d.f_start = 1'b1;
            d.cnt = 3'h0;
            d.tx = tx_byte_i;
            d.reload = 1'b0;
        end else begin
            if (~q.cs[2] & q.cs[1]) begin
                d.f_end = 1'b1;
                // released output returns to idle low
                d.tx = 8'h00;
                d.reload = 1'b0;
            end
            if (active & rise) begin
                d.rx = {q.rx[6:0], q.di[1]};
                d.cnt = q.cnt + 3'h1;
                if (q.cnt == 3'h7) begin
                    d.rx_v = 1'b1;
                    d.rx_b = {q.rx[6:0], q.di[1]};
                    d.reload = 1'b1;
                end
            end
            // outgoing bit changes on the falling edge, mode 0
            if (active & fall) begin
                if (q.reload) begin
                    d.tx = tx_byte_i;
                    d.reload = 1'b0;
                end else begin
                    d.tx = {q.tx[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '{cs: 3'h7, default: '0};
        end else begin
            q <= d;
        end
    end

    assign rx_valid_o = q.rx_v;
    assign rx_byte_o = q.rx_b;
    assign frame_start_o = q.f_start;
    assign frame_end_o = q.f_end;
    assign sdo_o = q.tx[7];

endmodule

// >>> verilog/protect_pkg.sv
// shared constants and types for the sector and password protection block
package protect_pkg;

    // ------------------------------------------------------------
    // command codes on the serial link
    // ------------------------------------------------------------
    localparam logic [7:0] OP_RD_PROT = 8'h41;
    localparam logic [7:0] OP_WR_PROT = 8'h42;
    localparam logic [7:0] OP_RD_PW = 8'h43;
    localparam logic [7:0] OP_WR_PW = 8'h44;
    localparam logic [7:0] OP_UNLOCK = 8'h45;
    localparam logic [7:0] OP_RD_FRZ = 8'h46;
    localparam logic [7:0] OP_WR_FRZ = 8'h47;
    localparam logic [7:0] OP_RD_NV = 8'h48;
    localparam logic [7:0] OP_WR_NV = 8'h49;
    localparam logic [7:0] OP_ER_NV = 8'h4a;
    localparam logic [7:0] OP_RD_VOL = 8'h4b;
    localparam logic [7:0] OP_WR_VOL = 8'h4c;

    // ------------------------------------------------------------
    // field positions and values after reset
    // ------------------------------------------------------------
    localparam int PROT_PW_BIT = 2;
    localparam int PROT_SL_BIT = 1;
    localparam logic [15:0] PROT_RESET = 16'hffff;
    localparam logic [63:0] PW_RESET = 64'hffff_ffff_ffff_ffff;
    localparam logic FRZ_RESET = 1'b0;
    localparam int VOL_DOWN_BIT = 1;
    localparam int VOL_WLOCK_BIT = 0;
    localparam int SECTOR_LSB = 16;
    localparam int SUBSEC_LSB = 12;
    localparam int SUBSEC_COUNT = 16;

    // ------------------------------------------------------------
    // frame byte counts
    // ------------------------------------------------------------
    localparam logic [1:0] ADDR_BYTES = 2'h3;
    localparam logic [3:0] PROT_BYTES = 4'h2;
    localparam logic [3:0] PW_BYTES = 4'h8;
    localparam logic [3:0] VOL_BYTES = 4'h1;
    localparam logic [3:0] DCNT_MAX = 4'hf;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;

    typedef enum logic [1:0] {
        PH_CMD = 2'b00,
        PH_ADDR = 2'b01,
        PH_DATA = 2'b11,
        PH_SKIP = 2'b10
    } phase_t;

endpackage

// >>> verilog/sector_password_protection.sv
// sector and password write protection for a serial flash
`timescale 1ns/1ps
module sector_password_protection #(
    parameter int SECTOR_BITS = 8,
    parameter int unsigned PROG_TIME_NS = 50000,
    parameter int unsigned ERASE_TIME_NS = 1000000
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic soft_rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    output logic sdo_o,
    input wire logic [23:0] wp_addr_i,
    output logic wp_block_o,
    output logic busy_o
);

    // ------------------------------------------------------------
    // sizes and timing
    // ------------------------------------------------------------
    localparam int NSEC = 1 << SECTOR_BITS;
    localparam int NVOL = NSEC + 2 * protect_pkg::SUBSEC_COUNT;
    localparam int VW = $clog2(NVOL);
    localparam int unsigned PROG_CYC =
        (PROG_TIME_NS + protect_pkg::CLK_PERIOD_NS - 1) / protect_pkg::CLK_PERIOD_NS;
    localparam int unsigned ERASE_CYC =
        (ERASE_TIME_NS + protect_pkg::CLK_PERIOD_NS - 1) / protect_pkg::CLK_PERIOD_NS;
    localparam logic [31:0] PROG_LEN = (PROG_CYC < 1) ? 32'h1 : 32'(PROG_CYC);
    localparam logic [31:0] ERASE_LEN = (ERASE_CYC < 1) ? 32'h1 : 32'(ERASE_CYC);

    typedef struct packed {
        protect_pkg::phase_t ph;
        logic [7:0] op;
        logic [23:0] addr;
        logic [1:0] acnt;
        logic [3:0] dcnt;
        logic [63:0] dbuf;
        logic [15:0] prot;
        logic [63:0] pw;
        logic frz;
        logic boot;
        logic [NSEC-1:0] nv;
        logic [NVOL-1:0][1:0] vol;
        logic blk;
    } prot_st_t;

    prot_st_t q;
    prot_st_t d;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic f_start;
    logic f_end;
    logic [7:0] tx_byte;
    logic tm_start;
    logic [31:0] tm_len;
    logic busy;
    logic pw_mode;
    logic [SECTOR_BITS-1:0] sec;
    logic [VW-1:0] vidx;
    logic [1:0] new_mode;

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    function automatic logic takes_addr(input logic [7:0] op);
        takes_addr = (op == protect_pkg::OP_RD_NV) || (op == protect_pkg::OP_WR_NV) ||
                     (op == protect_pkg::OP_RD_VOL) || (op == protect_pkg::OP_WR_VOL);
    endfunction

    function automatic logic [SECTOR_BITS-1:0] sector_of(input logic [23:0] a);
        sector_of = a[protect_pkg::SECTOR_LSB +: SECTOR_BITS];
    endfunction

    // end sectors map each 4KB subsector to a slot of its own
    function automatic logic [VW-1:0] vol_slot(input logic [23:0] a);
        logic [SECTOR_BITS-1:0] s;
        logic [3:0] sub;
        s = a[protect_pkg::SECTOR_LSB +: SECTOR_BITS];
        sub = a[protect_pkg::SUBSEC_LSB +: 4];
        if (s == '0) begin
            vol_slot = VW'(NSEC) + VW'(sub);
        end else if (s == SECTOR_BITS'(NSEC - 1)) begin
            vol_slot = VW'(NSEC + protect_pkg::SUBSEC_COUNT) + VW'(sub);
        end else begin
            vol_slot = VW'(s);
        end
    endfunction

    // ------------------------------------------------------------
    // link and timer
    // ------------------------------------------------------------
    link_sampler u_link (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .sclk_i(sclk_i),
        .cs_n_i(cs_n_i),
        .sdi_i(sdi_i),
        .tx_byte_i(tx_byte),
        .rx_valid_o(rx_valid),
        .rx_byte_o(rx_byte),
        .frame_start_o(f_start),
        .frame_end_o(f_end),
        .sdo_o(sdo_o)
    );

    busy_timer #(
        .W(32)
    ) u_timer (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .start_i(tm_start),
        .len_i(tm_len),
        .busy_o(busy)
    );

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        tx_byte = 8'h00;
        if (q.ph == protect_pkg::PH_DATA) begin
            case (q.op)
                protect_pkg::OP_RD_PROT: begin
                    tx_byte = (q.dcnt == 4'h0) ? q.prot[7:0] : q.prot[15:8];
                end
                protect_pkg::OP_RD_PW: begin
                    tx_byte = pw_mode ? 8'hff : q.pw[8 * q.dcnt[2:0] +: 8];
                end
                protect_pkg::OP_RD_FRZ: begin
                    tx_byte = {7'h00, q.frz};
                end
                protect_pkg::OP_RD_NV: begin
                    tx_byte = {7'h00, q.nv[sector_of(q.addr)]};
                end
                protect_pkg::OP_RD_VOL: begin
                    tx_byte = {6'h00, q.vol[vol_slot(q.addr)]};
                end
                default: begin
                    tx_byte = 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // command handling
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        tm_start = 1'b0;
        tm_len = PROG_LEN;
        pw_mode = ~q.prot[protect_pkg::PROT_PW_BIT];
        sec = sector_of(q.addr);
        vidx = vol_slot(q.addr);
        new_mode = q.dbuf[48 + protect_pkg::PROT_SL_BIT +: 2];
        // freeze reloaded once after any reset
        if (q.boot) begin
            d.frz = q.prot[protect_pkg::PROT_PW_BIT];
            d.boot = 1'b0;
        end
        if (f_start) begin
            d.ph = protect_pkg::PH_CMD;
            d.acnt = 2'h0;
            d.dcnt = 4'h0;
        end else if (rx_valid) begin
            case (q.ph)
                protect_pkg::PH_CMD: begin
                    d.op = rx_byte;
                    d.ph = takes_addr(rx_byte) ? protect_pkg::PH_ADDR : protect_pkg::PH_DATA;
                end
                protect_pkg::PH_ADDR: begin
                    d.addr = {q.addr[15:0], rx_byte};
                    d.acnt = q.acnt + 2'h1;
                    if (q.acnt == protect_pkg::ADDR_BYTES - 2'h1) begin
                        d.ph = protect_pkg::PH_DATA;
                    end
                end
                protect_pkg::PH_DATA: begin
                    d.dbuf = {rx_byte, q.dbuf[63:8]};
                    if (q.dcnt != protect_pkg::DCNT_MAX) begin
                        d.dcnt = q.dcnt + 4'h1;
                    end
                end
                default: begin
                    d.ph = protect_pkg::PH_SKIP;
                end
            endcase
        end else if (f_end && q.ph == protect_pkg::PH_DATA && !q.boot) begin
            d.ph = protect_pkg::PH_SKIP;
            case (q.op)
                protect_pkg::OP_WR_PROT: begin
                    // one-shot: both bits still one, exactly one cleared
                    if (!busy && q.dcnt >= protect_pkg::PROT_BYTES && q.prot[2:1] == 2'b11 &&
                        ^new_mode) begin
                        d.prot[protect_pkg::PROT_SL_BIT +: 2] = new_mode;
                        tm_start = 1'b1;
                    end
                end
                protect_pkg::OP_WR_PW: begin
                    if (!busy && !pw_mode && q.dcnt >= protect_pkg::PW_BYTES) begin
                        d.pw = q.dbuf;
                        tm_start = 1'b1;
                    end
                end
                protect_pkg::OP_UNLOCK: begin
                    if (q.dcnt >= protect_pkg::PW_BYTES && q.dbuf == q.pw) begin
                        d.frz = 1'b1;
                    end
                end
                protect_pkg::OP_WR_FRZ: begin
                    d.frz = 1'b0;
                end
                protect_pkg::OP_WR_NV: begin
                    if (!busy && q.frz) begin
                        d.nv[sec] = 1'b0;
                        tm_start = 1'b1;
                    end
                end
                protect_pkg::OP_ER_NV: begin
                    if (!busy && q.frz) begin
                        d.nv = '1;
                        tm_start = 1'b1;
                        tm_len = ERASE_LEN;
                    end
                end
                protect_pkg::OP_WR_VOL: begin
                    if (q.dcnt >= protect_pkg::VOL_BYTES && !q.vol[vidx][protect_pkg::VOL_DOWN_BIT]) begin
                        d.vol[vidx] = q.dbuf[57:56];
                    end
                end
                default: begin
                    d.ph = protect_pkg::PH_SKIP;
                end
            endcase
        end
        // software reset drops volatile state only
        if (soft_rst_i) begin
            d.vol = '0;
            d.boot = 1'b1;
            d.ph = protect_pkg::PH_SKIP;
        end
        // program/erase gate for the flash array
        d.blk = ~q.nv[sector_of(wp_addr_i)] |
                q.vol[vol_slot(wp_addr_i)][protect_pkg::VOL_WLOCK_BIT];
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q.ph <= protect_pkg::PH_SKIP;
            q.op <= 8'h00;
            q.addr <= 24'h000000;
            q.acnt <= 2'h0;
            q.dcnt <= 4'h0;
            q.dbuf <= 64'h0000_0000_0000_0000;
            q.prot <= protect_pkg::PROT_RESET;
            q.pw <= protect_pkg::PW_RESET;
            q.frz <= protect_pkg::FRZ_RESET;
            q.boot <= 1'b1;
            q.nv <= '1;
            q.vol <= '0;
            q.blk <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wp_block_o = q.blk;
    assign busy_o = busy;

endmodule
